// >>> acr_analog_model.sv
// acr_analog_model: stand-in for the analog section feeding status and digital test sources.
// assumes the bench clock and reset; sources change every cycle so a stale mux pick shows.
`timescale 1ns/1ps
module acr_analog_model
	import acr_pkg::*;
(
	// clock and reset
	input  wire logic   clk_i,
	input  wire logic   rst_i,
	// request from the bench
	input  wire logic   ov_req_i,
	// status toward the registers
	output acr_dig_src_t dig_src_o,
	output logic         ov_protect_active_o
);
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dig_src_o <= 7'h2a;
		end else begin
			dig_src_o <= dig_src_o + 7'h35;
		end
	end
	always_ff @(posedge clk_i) begin
		ov_protect_active_o <= ov_req_i;
	end
endmodule : acr_analog_model

// >>> acr_pkg.sv
// acr_pkg: register map, field positions, reset values and carrier types for the analog control registers.
// assumes a 32-bit classic wishbone slave with word-aligned registers.
package acr_pkg;

	localparam int ACR_AW = 4;

	// register byte addresses
	localparam logic [ACR_AW-1:0] ACR_PE_ADDR   = 4'h0;
	localparam logic [ACR_AW-1:0] ACR_ABE_ADDR  = 4'h4;
	localparam logic [ACR_AW-1:0] ACR_MODE_ADDR = 4'h8;

	// implemented bits and reset values
	localparam logic [7:0] ACR_PE_MASK    = 8'hf7;
	localparam logic [7:0] ACR_ABE_MASK   = 8'hfb;
	localparam logic [7:0] ACR_MODE_MASK  = 8'he0;
	localparam logic [7:0] ACR_PE_RESET   = 8'h04;
	localparam logic [7:0] ACR_ABE_RESET  = 8'h00;
	localparam logic [7:0] ACR_MODE_RESET = 8'h00;

	// peripheral enable fields
	localparam int ACR_PE_PRIMARY_DRIVER_OUT_EN  = 7;
	localparam int ACR_PE_SECONDARY_DRIVER_OUT_EN  = 6;
	localparam int ACR_PE_PRIMARY_DRIVER_OUT_BY  = 5;
	localparam int ACR_PE_SECONDARY_DRIVER_OUT_BY  = 4;
	localparam int ACR_PE_PULLUP   = 2;
	localparam int ACR_PE_PSTEER   = 1;
	localparam int ACR_PE_SSTEER   = 0;

	// analog block enable fields
	localparam int ACR_ABE_DIGOE   = 7;
	localparam int ACR_ABE_DIGITAL_TEST_SELECT_HI = 6;
	localparam int ACR_ABE_DIGITAL_TEST_SELECT_LO = 4;
	localparam int ACR_ABE_UVLO    = 3;
	localparam int ACR_ABE_ERROR_AMP_DISABLE   = 1;
	localparam int ACR_ABE_ANAOE   = 0;

	// mode fields
	localparam int ACR_MODE_ROLE_HI = 7;
	localparam int ACR_MODE_ROLE_LO = 6;
	localparam int ACR_MODE_RFB     = 5;

	typedef enum logic [1:0] {
		ACR_ROLE_ALONE     = 2'h0,
		ACR_ROLE_MAIN      = 2'h1,
		ACR_ROLE_SECONDARY = 2'h2,
		ACR_ROLE_RESERVED  = 2'h3
	} acr_role_t;

	typedef enum logic [2:0] {
		ACR_DIGITAL_TEST_SELECT_DESAT   = 3'h0,
		ACR_DIGITAL_TEST_SELECT_PWML    = 3'h1,
		ACR_DIGITAL_TEST_SELECT_OSC     = 3'h2,
		ACR_DIGITAL_TEST_SELECT_TMR2    = 3'h3,
		ACR_DIGITAL_TEST_SELECT_OV      = 3'h4,
		ACR_DIGITAL_TEST_SELECT_SWITCHING_FREQUENCY_OUT   = 3'h5,
		ACR_DIGITAL_TEST_SELECT_ONESHOT = 3'h6,
		ACR_DIGITAL_TEST_SELECT_NONE    = 3'h7
	} acr_digital_test_select_t;

	// digital test sources from the rest of the controller
	typedef struct packed {
		logic desat_comparator_out;
		logic pwm_after_monostable;
		logic oscillator_pwm;
		logic timer2_period_match;
		logic overvoltage_comparator;
		logic switching_frequency_out;
		logic secondary_oneshot_pulse;
	} acr_dig_src_t;

	// control bundle into the analog section
	typedef struct packed {
		logic primary_drive_enable;
		logic secondary_drive_enable;
		logic primary_deadtime_bypass;
		logic secondary_deadtime_bypass;
		logic sense_pin_pullup_enable;
		logic primary_steer_active;
		logic secondary_steer_active;
		logic gate_uvlo_select;
		logic error_amp_disable;
		logic feedback_mux_select;
		logic second_reference_to_pin;
		logic test_pin_digital;
		logic test_pin_analog;
		logic analog_to_adc;
	} acr_ctrl_t;

endpackage : acr_pkg

// >>> acr_regs.sv
// acr_regs: three 8-bit analog control registers on a classic wishbone slave, with the derived control outputs.
// assumes one 10 MHz clock, synchronous active-high reset and synchronous inputs.
//
// Overview of operation
// RULE_01 - bits 7 and 6 enable primary, secondary drivers
// RULE_02 - bits 5 and 4 bypass driver dead time
// RULE_03 - bit 2 enables sense pull-up, resets one
// RULE_04 - bit 1 enables primary open-loop steering
// RULE_05 - bit 0 enables secondary open-loop steering
// RULE_06 - primary steering dominates when both set
// RULE_07 - secondary steering needs overvoltage protection active
// RULE_08 - bit 7 puts digital test mux on pin
// RULE_09 - three-bit select picks digital test source
// RULE_10 - bit 0 puts analog test mux on pin
// RULE_11 - digital wins pin when both enabled
// RULE_12 - analog test goes to adc when disabled
// RULE_13 - bit 3 picks high or low uvlo
// RULE_14 - uvlo select and amp disable reset zero
// RULE_15 - bit 1 disables error amp, parks low
// RULE_16 - role field bits 7..6 encodes device role
// RULE_17 - main role connects second reference buffer
// RULE_18 - second reference on port pin only role 01
// RULE_19 - bit 5 steers current amp feedback mux
// RULE_20 - unimplemented bits ignore writes, read zero
// RULE_21 - single-cycle write, outputs follow next cycle
// RULE_22 - unimplemented digital code drives constant low
//
// Decided for this implementation: register access over Wishbone and the address map.
`timescale 1ns/1ps
module acr_regs
	import acr_pkg::*;
(
	// clock, reset, enable
	input  wire logic                clk_i,
	input  wire logic                rst_i,
	input  wire logic                ce_i,
	// wishbone slave
	input  wire logic                wb_cyc_i,
	input  wire logic                wb_stb_i,
	input  wire logic                wb_we_i,
	input  wire logic [ACR_AW-1:0]   wb_adr_i,
	input  wire logic [3:0]          wb_sel_i,
	input  wire logic [31:0]         wb_dat_i,
	output logic      [31:0]         wb_dat_o,
	output logic                     wb_ack_o,
	output logic                     wb_err_o,
	// status from the analog section
	input  wire logic                ov_protect_active_i,
	input  wire acr_dig_src_t        dig_src_i,
	// controls to the analog section
	output acr_ctrl_t                ctrl_o,
	output logic [1:0]               device_role_o,
	output logic                     test_pin_o
);

	logic [7:0] pe_q;
	logic [7:0] abe_q;
	logic [7:0] mode_q;
	logic       req;
	logic       hit;
	logic       wr;
	logic       dig_mux;
	logic [7:0] rd_sel;
	acr_ctrl_t  ctrl_d;

	// new request only when no ack is outstanding, giving one ack per cycle pair
	assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
	assign hit = (wb_adr_i == ACR_PE_ADDR) | (wb_adr_i == ACR_ABE_ADDR) | (wb_adr_i == ACR_MODE_ADDR);
	assign wr  = req & hit & wb_we_i & wb_sel_i[0];

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pe_q <= ACR_PE_RESET; // see RULE_03
		end else if (ce_i && wr && wb_adr_i == ACR_PE_ADDR) begin
			pe_q <= wb_dat_i[7:0] & ACR_PE_MASK; // see RULE_20
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			abe_q <= ACR_ABE_RESET; // see RULE_14
		end else if (ce_i && wr && wb_adr_i == ACR_ABE_ADDR) begin
			abe_q <= wb_dat_i[7:0] & ACR_ABE_MASK; // see RULE_20
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mode_q <= ACR_MODE_RESET;
		end else if (ce_i && wr && wb_adr_i == ACR_MODE_ADDR) begin
			mode_q <= wb_dat_i[7:0] & ACR_MODE_MASK; // see RULE_20
		end
	end

	always_comb begin
		unique case (wb_adr_i)
			ACR_PE_ADDR:   rd_sel = pe_q;
			ACR_ABE_ADDR:  rd_sel = abe_q;
			ACR_MODE_ADDR: rd_sel = mode_q;
			default:       rd_sel = 8'h00;
		endcase
	end

	// bus answer: ack one cycle after the request, err for unmapped addresses
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_err_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else if (ce_i) begin
			wb_ack_o <= req & hit; // see RULE_21
			wb_err_o <= req & ~hit;
			wb_dat_o <= {24'h00_0000, (req & hit & ~wb_we_i) ? rd_sel : 8'h00};
		end
	end

	always_comb begin
		unique case (acr_digital_test_select_t'(abe_q[ACR_ABE_DIGITAL_TEST_SELECT_HI:ACR_ABE_DIGITAL_TEST_SELECT_LO])) // see RULE_09
			ACR_DIGITAL_TEST_SELECT_DESAT:   dig_mux = dig_src_i.desat_comparator_out;
			ACR_DIGITAL_TEST_SELECT_PWML:    dig_mux = dig_src_i.pwm_after_monostable;
			ACR_DIGITAL_TEST_SELECT_OSC:     dig_mux = dig_src_i.oscillator_pwm;
			ACR_DIGITAL_TEST_SELECT_TMR2:    dig_mux = dig_src_i.timer2_period_match;
			ACR_DIGITAL_TEST_SELECT_OV:      dig_mux = dig_src_i.overvoltage_comparator;
			ACR_DIGITAL_TEST_SELECT_SWITCHING_FREQUENCY_OUT:   dig_mux = dig_src_i.switching_frequency_out;
			ACR_DIGITAL_TEST_SELECT_ONESHOT: dig_mux = dig_src_i.secondary_oneshot_pulse;
			ACR_DIGITAL_TEST_SELECT_NONE:    dig_mux = 1'b0; // see RULE_22
		endcase
	end

	always_comb begin
		ctrl_d.primary_drive_enable      = pe_q[ACR_PE_PRIMARY_DRIVER_OUT_EN]; // see RULE_01
		ctrl_d.secondary_drive_enable    = pe_q[ACR_PE_SECONDARY_DRIVER_OUT_EN]; // see RULE_01
		ctrl_d.primary_deadtime_bypass   = pe_q[ACR_PE_PRIMARY_DRIVER_OUT_BY]; // see RULE_02
		ctrl_d.secondary_deadtime_bypass = pe_q[ACR_PE_SECONDARY_DRIVER_OUT_BY]; // see RULE_02
		ctrl_d.sense_pin_pullup_enable   = pe_q[ACR_PE_PULLUP]; // see RULE_03
		ctrl_d.primary_steer_active      = pe_q[ACR_PE_PSTEER]; // see RULE_04
		// see RULE_05, see RULE_06, see RULE_07
		ctrl_d.secondary_steer_active    = pe_q[ACR_PE_SSTEER] & ~pe_q[ACR_PE_PSTEER] & ov_protect_active_i;
		ctrl_d.gate_uvlo_select          = abe_q[ACR_ABE_UVLO]; // see RULE_13
		ctrl_d.error_amp_disable         = abe_q[ACR_ABE_ERROR_AMP_DISABLE]; // see RULE_15
		ctrl_d.feedback_mux_select       = mode_q[ACR_MODE_RFB]; // see RULE_19
		// see RULE_17, see RULE_18
		ctrl_d.second_reference_to_pin   = mode_q[ACR_MODE_ROLE_HI:ACR_MODE_ROLE_LO] == ACR_ROLE_MAIN;
		ctrl_d.test_pin_digital          = abe_q[ACR_ABE_DIGOE]; // see RULE_08
		ctrl_d.test_pin_analog           = abe_q[ACR_ABE_ANAOE] & ~abe_q[ACR_ABE_DIGOE]; // see RULE_10, see RULE_11
		ctrl_d.analog_to_adc             = ~abe_q[ACR_ABE_ANAOE]; // see RULE_12
	end

	// registered outputs, one cycle behind the register state
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_o        <= '0;
			device_role_o <= ACR_ROLE_ALONE;
			test_pin_o    <= 1'b0;
		end else if (ce_i) begin
			ctrl_o        <= ctrl_d; // see RULE_21
			device_role_o <= mode_q[ACR_MODE_ROLE_HI:ACR_MODE_ROLE_LO]; // see RULE_16
			test_pin_o    <= abe_q[ACR_ABE_DIGOE] & dig_mux; // see RULE_08
		end
	end

	property p_write_ack;
		@(posedge clk_i) disable iff (rst_i)
		(ce_i && req && hit) |=> wb_ack_o;
	endproperty
	a_write_ack: assert property (p_write_ack) else $error("no ack after mapped request"); // see RULE_21

	property p_reserved_zero;
		@(posedge clk_i) disable iff (rst_i)
		((pe_q & ~ACR_PE_MASK) == 8'h00) && ((abe_q & ~ACR_ABE_MASK) == 8'h00) && ((mode_q & ~ACR_MODE_MASK) == 8'h00);
	endproperty
	a_reserved_zero: assert property (p_reserved_zero) else $error("unimplemented bit set"); // see RULE_20

	property p_prim_dominant;
		@(posedge clk_i) disable iff (rst_i)
		(ce_i && pe_q[ACR_PE_PSTEER]) |=> !ctrl_o.secondary_steer_active;
	endproperty
	a_prim_dominant: assert property (p_prim_dominant) else $error("secondary steering with primary set"); // see RULE_06

	property p_sec_needs_ov;
		@(posedge clk_i) disable iff (rst_i)
		(ce_i && !ov_protect_active_i) |=> !ctrl_o.secondary_steer_active;
	endproperty
	a_sec_needs_ov: assert property (p_sec_needs_ov) else $error("secondary steering without ov"); // see RULE_07

	property p_digital_wins;
		@(posedge clk_i) disable iff (rst_i)
		ctrl_o.test_pin_digital |-> !ctrl_o.test_pin_analog;
	endproperty
	a_digital_wins: assert property (p_digital_wins) else $error("both test paths on pin"); // see RULE_11

	property p_second_reference_main;
		@(posedge clk_i) disable iff (rst_i)
		ctrl_o.second_reference_to_pin |-> device_role_o == ACR_ROLE_MAIN;
	endproperty
	a_second_reference_main: assert property (p_second_reference_main) else $error("second reference out of main role"); // see RULE_18

	property p_unimpl_low;
		@(posedge clk_i) disable iff (rst_i)
		(ce_i && abe_q[ACR_ABE_DIGITAL_TEST_SELECT_HI:ACR_ABE_DIGITAL_TEST_SELECT_LO] == ACR_DIGITAL_TEST_SELECT_NONE) |=> !test_pin_o;
	endproperty
	a_unimpl_low: assert property (p_unimpl_low) else $error("test pin high on unused code"); // see RULE_22

	property p_drive_follows;
		@(posedge clk_i) disable iff (rst_i)
		ce_i |=> ctrl_o.primary_drive_enable == $past(pe_q[ACR_PE_PRIMARY_DRIVER_OUT_EN]);
	endproperty
	a_drive_follows: assert property (p_drive_follows) else $error("drive enable not following"); // see RULE_01

	sequence s_mapped_req;
		ce_i && req && hit;
	endsequence

	sequence s_ack_only;
		wb_ack_o && !wb_err_o;
	endsequence

	property p_mapped_answer;
		@(posedge clk_i) disable iff (rst_i)
		s_mapped_req |=> s_ack_only;
	endproperty
	a_mapped_answer: assert property (p_mapped_answer) else $error("mapped request not acked alone"); // see RULE_21

	property p_unmapped_err;
		@(posedge clk_i) disable iff (rst_i)
		(ce_i && req && !hit) |=> (wb_err_o && !wb_ack_o);
	endproperty
	a_unmapped_err: assert property (p_unmapped_err) else $error("unmapped request not refused"); // see RULE_21

	property p_ack_pulse;
		@(posedge clk_i) disable iff (rst_i)
		(ce_i && wb_ack_o) |=> !wb_ack_o;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle"); // see RULE_21

	property p_err_pulse;
		@(posedge clk_i) disable iff (rst_i)
		(ce_i && wb_err_o) |=> !wb_err_o;
	endproperty
	a_err_pulse: assert property (p_err_pulse) else $error("err longer than one cycle"); // see RULE_21

	property p_read_pe;
		@(posedge clk_i) disable iff (rst_i)
		(ce_i && req && hit && !wb_we_i && wb_adr_i == ACR_PE_ADDR) |=> (wb_dat_o == {24'h00_0000, $past(pe_q)});
	endproperty
	a_read_pe: assert property (p_read_pe) else $error("peripheral enable read wrong"); // see RULE_21

	property p_read_abe;
		@(posedge clk_i) disable iff (rst_i)
		(ce_i && req && hit && !wb_we_i && wb_adr_i == ACR_ABE_ADDR) |=> (wb_dat_o == {24'h00_0000, $past(abe_q)});
	endproperty
	a_read_abe: assert property (p_read_abe) else $error("analog block enable read wrong"); // see RULE_21

	property p_read_mode;
		@(posedge clk_i) disable iff (rst_i)
		(ce_i && req && hit && !wb_we_i && wb_adr_i == ACR_MODE_ADDR) |=> (wb_dat_o == {24'h00_0000, $past(mode_q)});
	endproperty
	a_read_mode: assert property (p_read_mode) else $error("mode read wrong"); // see RULE_21

	property p_idle_data;
		@(posedge clk_i) disable iff (rst_i)
		(ce_i && !(req && hit && !wb_we_i)) |=> (wb_dat_o == 32'h0000_0000);
	endproperty
	a_idle_data: assert property (p_idle_data) else $error("read data outside read answer"); // see RULE_21

	property p_pe_write;
		@(posedge clk_i) disable iff (rst_i)
		(ce_i && wr && wb_adr_i == ACR_PE_ADDR) |=> (pe_q == ($past(wb_dat_i[7:0]) & ACR_PE_MASK));
	endproperty
	a_pe_write: assert property (p_pe_write) else $error("peripheral enable write lost"); // see RULE_20

	property p_abe_write;
		@(posedge clk_i) disable iff (rst_i)
		(ce_i && wr && wb_adr_i == ACR_ABE_ADDR) |=> (abe_q == ($past(wb_dat_i[7:0]) & ACR_ABE_MASK));
	endproperty
	a_abe_write: assert property (p_abe_write) else $error("analog block enable write lost"); // see RULE_20

	property p_mode_write;
		@(posedge clk_i) disable iff (rst_i)
		(ce_i && wr && wb_adr_i == ACR_MODE_ADDR) |=> (mode_q == ($past(wb_dat_i[7:0]) & ACR_MODE_MASK));
	endproperty
	a_mode_write: assert property (p_mode_write) else $error("mode write lost"); // see RULE_20

	property p_regs_hold;
		@(posedge clk_i) disable iff (rst_i)
		(!rst_i && !(ce_i && wr)) |=> ($stable(pe_q) && $stable(abe_q) && $stable(mode_q));
	endproperty
	a_regs_hold: assert property (p_regs_hold) else $error("register changed without write"); // see RULE_21

	property p_frozen_outputs;
		@(posedge clk_i) disable iff (rst_i)
		(!rst_i && !ce_i) |=> ($stable(ctrl_o) && $stable(device_role_o) && $stable(test_pin_o));
	endproperty
	a_frozen_outputs: assert property (p_frozen_outputs) else $error("outputs moved while frozen"); // see RULE_21

	property p_frozen_bus;
		@(posedge clk_i) disable iff (rst_i)
		(!rst_i && !ce_i) |=> ($stable(wb_ack_o) && $stable(wb_err_o) && $stable(wb_dat_o));
	endproperty
	a_frozen_bus: assert property (p_frozen_bus) else $error("bus answer moved while frozen"); // see RULE_21

	property p_prim_bypass;
		@(posedge clk_i) disable iff (rst_i)
		(ce_i && !rst_i) |=> (ctrl_o.primary_deadtime_bypass == $past(pe_q[ACR_PE_PRIMARY_DRIVER_OUT_BY]));
	endproperty
	a_prim_bypass: assert property (p_prim_bypass) else $error("dead time bypass not following"); // see RULE_02

	property p_pullup_follows;
		@(posedge clk_i) disable iff (rst_i)
		(ce_i && !rst_i) |=> (ctrl_o.sense_pin_pullup_enable == $past(pe_q[ACR_PE_PULLUP]));
	endproperty
	a_pullup_follows: assert property (p_pullup_follows) else $error("pullup enable not following"); // see RULE_03

	property p_prim_steer;
		@(posedge clk_i) disable iff (rst_i)
		(ce_i && !rst_i) |=> (ctrl_o.primary_steer_active == $past(pe_q[ACR_PE_PSTEER]));
	endproperty
	a_prim_steer: assert property (p_prim_steer) else $error("primary steering not following"); // see RULE_04

	property p_sec_steer;
		@(posedge clk_i) disable iff (rst_i)
		(ce_i && !rst_i && pe_q[ACR_PE_SSTEER] && !pe_q[ACR_PE_PSTEER] && ov_protect_active_i) |=> ctrl_o.secondary_steer_active;
	endproperty
	a_sec_steer: assert property (p_sec_steer) else $error("secondary steering not on"); // see RULE_05

	property p_test_pin_off;
		@(posedge clk_i) disable iff (rst_i)
		(ce_i && !rst_i && !abe_q[ACR_ABE_DIGOE]) |=> !test_pin_o;
	endproperty
	a_test_pin_off: assert property (p_test_pin_off) else $error("test pin driven while disabled"); // see RULE_08

	property p_digital_test_select_tmr2;
		@(posedge clk_i) disable iff (rst_i)
		(ce_i && !rst_i && abe_q[ACR_ABE_DIGOE] && abe_q[ACR_ABE_DIGITAL_TEST_SELECT_HI:ACR_ABE_DIGITAL_TEST_SELECT_LO] == ACR_DIGITAL_TEST_SELECT_TMR2)
			|=> (test_pin_o == $past(dig_src_i.timer2_period_match));
	endproperty
	a_digital_test_select_tmr2: assert property (p_digital_test_select_tmr2) else $error("timer match not on test pin"); // see RULE_09

	property p_adc_route;
		@(posedge clk_i) disable iff (rst_i)
		(ce_i && !rst_i) |=> (ctrl_o.analog_to_adc == !$past(abe_q[ACR_ABE_ANAOE]));
	endproperty
	a_adc_route: assert property (p_adc_route) else $error("analog test not routed to adc"); // see RULE_12

	property p_role_follows;
		@(posedge clk_i) disable iff (rst_i)
		(ce_i && !rst_i) |=> (device_role_o == $past(mode_q[ACR_MODE_ROLE_HI:ACR_MODE_ROLE_LO]));
	endproperty
	a_role_follows: assert property (p_role_follows) else $error("device role not following"); // see RULE_16

	property p_vref_main;
		@(posedge clk_i) disable iff (rst_i)
		(ce_i && !rst_i && mode_q[ACR_MODE_ROLE_HI:ACR_MODE_ROLE_LO] == ACR_ROLE_MAIN) |=> ctrl_o.second_reference_to_pin;
	endproperty
	a_vref_main: assert property (p_vref_main) else $error("second reference missing in main role"); // see RULE_17

	property p_reset_values;
		@(posedge clk_i)
		rst_i |=> (pe_q == ACR_PE_RESET) && (abe_q == ACR_ABE_RESET) && (mode_q == ACR_MODE_RESET);
	endproperty
	a_reset_values: assert property (p_reset_values) else $error("register reset value wrong"); // see RULE_14

endmodule : acr_regs

// >>> tb_top.sv
// tb_top: register bank bench with a behavioural register model compared every cycle.
// assumes the design answers one cycle after a request and outputs follow one cycle later.
`timescale 1ns/1ps
module tb_top;
	import acr_pkg::*;
	logic              clk_i = 0, rst_i = 1, ce_i = 1, cyc = 0, stb = 0, we = 0, ov_req = 0, rst_q = 1;
	logic [ACR_AW-1:0] adr = '0;
	logic [3:0]        sel = '0;
	logic [31:0]       dat_w = '0, dat_r;
	logic              ack, err, tpin, ov, ov_q;
	logic [1:0]        role;
	acr_ctrl_t         ctrl;
	acr_dig_src_t      src, src_q;
	logic [7:0]        m_pe = ACR_PE_RESET, m_abe = ACR_ABE_RESET, m_mode = ACR_MODE_RESET;
	logic [16:0]       ev, ev_last = '0;
	logic              ce_q = 1;
	int                failures = 0, n_tests = 0, cycles = 0;

	acr_regs dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_w), .wb_dat_o(dat_r), .wb_ack_o(ack), .wb_err_o(err),
		.ov_protect_active_i(ov), .dig_src_i(src), .ctrl_o(ctrl), .device_role_o(role), .test_pin_o(tpin));
	acr_analog_model far (.clk_i(clk_i), .rst_i(rst_i), .ov_req_i(ov_req), .dig_src_o(src),
		.ov_protect_active_o(ov));

	always #50 clk_i = ~clk_i;

	task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			failures++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task report_and_stop;
		$display("comparisons %0d failures %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : report_and_stop

	task wb(input logic w, input logic [3:0] a, input logic [7:0] d, input logic [3:0] s);
		logic        e, k, hit;
		logic [7:0]  mr;
		logic [31:0] rd;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat_w <= {24'h0, d};
		sel <= s;
		// ack or err ends this wait; the bench timeout ends it if neither comes
		do begin
			@(posedge clk_i);
		end while (ack !== 1'b1 && err !== 1'b1);
		rd = dat_r;
		e = err;
		k = ack;
		cyc <= 1'b0;
		stb <= 1'b0;
		hit = 1'b1;
		mr = 8'h00;
		case (a)
			ACR_PE_ADDR: begin
				if (w && s[0]) m_pe = d & ACR_PE_MASK;
				mr = m_pe;
			end
			ACR_ABE_ADDR: begin
				if (w && s[0]) m_abe = d & ACR_ABE_MASK;
				mr = m_abe;
			end
			ACR_MODE_ADDR: begin
				if (w && s[0]) m_mode = d & ACR_MODE_MASK;
				mr = m_mode;
			end
			default: hit = 1'b0;
		endcase
		check("ack", {31'h0, k}, {31'h0, hit});
		check("err", {31'h0, e}, {31'h0, ~hit});
		if (!w && hit) check("rdata", rd, {24'h0, mr});
	endtask : wb

	always @(posedge clk_i) begin
		rst_q <= rst_i;
		src_q <= src;
		ov_q <= ov;
		ce_q <= ce_i;
		cycles <= cycles + 1;
		if (cycles > 20000) begin
			failures++;
			report_and_stop;
		end
	end

	always @(negedge clk_i) begin
		if (cycles > 0) begin
			if (!ack) check("rdata idle", dat_r, 32'h0);
			if (ce_q) begin
				ev = rst_q ? 17'h0 : {m_pe[7], m_pe[6], m_pe[5], m_pe[4], m_pe[2], m_pe[1],
					m_pe[0] & ~m_pe[1] & ov_q, m_abe[3], m_abe[1], m_mode[5], m_mode[7:6] == 2'h1, m_abe[7],
					m_abe[0] & ~m_abe[7], ~m_abe[0], m_mode[7:6],
					m_abe[7] & (m_abe[6:4] != 3'h7) & src_q[3'h6 - m_abe[6:4]]};
				check("outputs", {15'h0, ctrl, role, tpin}, {15'h0, ev});
				ev_last = ev;
			end else begin
				// clock enable low: outputs hold the last expected state and ack stays low
				check("frozen outputs", {15'h0, ctrl, role, tpin}, {15'h0, ev_last});
				check("frozen ack", {31'h0, ack}, 32'h0);
			end
		end
	end

	initial begin
		void'($urandom(32'h773689cc));
		repeat (6) @(posedge clk_i);
		rst_i <= 0;
		for (int i = 0; i < 4; i++) wb(0, 4'(4 * i), 8'h0, 4'hf);
		for (int k = 0; k < 8; k++) begin
			wb(1, ACR_ABE_ADDR, {1'b1, 3'(k), 4'hf}, 4'h1);
			wb(0, ACR_ABE_ADDR, 8'h0, 4'h1);
		end
		for (int r = 0; r < 4; r++) begin
			wb(1, ACR_MODE_ADDR, {2'(r), 6'h3f}, 4'h1);
			wb(0, ACR_MODE_ADDR, 8'h0, 4'h1);
		end
		for (int i = 0; i < 80; i++) begin
			ov_req <= 1'($urandom);
			wb(1'($urandom), 4'(($urandom % 4) * 4), 8'($urandom), 4'($urandom));
		end
		@(posedge clk_i);
		rst_i <= 1;
		// model resets at the edge where the design first samples reset
		@(posedge clk_i);
		m_pe = ACR_PE_RESET;
		m_abe = ACR_ABE_RESET;
		m_mode = ACR_MODE_RESET;
		@(posedge clk_i);
		rst_i <= 0;
		for (int i = 0; i < 3; i++) wb(0, 4'(4 * i), 8'h0, 4'hf);
		// digital test on timer match, secondary steering with protection active
		wb(1, ACR_ABE_ADDR, 8'hb0, 4'h1);
		ov_req <= 1'b1;
		wb(1, ACR_PE_ADDR, 8'h01, 4'h1);
		// request pending while the clock enable is low, protection dropped meanwhile
		fork
			wb(1, ACR_MODE_ADDR, 8'h60, 4'h1);
			begin
				ce_i <= 1'b0;
				ov_req <= 1'b0;
				repeat (6) @(posedge clk_i);
				ce_i <= 1'b1;
			end
		join
		wb(0, ACR_MODE_ADDR, 8'h0, 4'h1);
		wb(0, ACR_PE_ADDR, 8'h0, 4'h1);
		report_and_stop;
	end
endmodule : tb_top
